// ===== hdl/twp_write_port.sv
// Three-wire serial write port with register array and readback bus
//
// Behaviour
// R01 - Serial bits gather in a 16-bit word: 6 address bits, 10 data.
// R02 - A valid commit writes the 10 data bits to the addressed register.
// R03 - Commit happens only after exactly 16 rising shift edges inside one frame.
// R04 - Fewer or more edges discard the word; no register changes.
// R05 - Address is checked; undefined addresses discard the word and change nothing.
// R06 - With readback on, selected register appears on output bus bits 11:2.
// R07 - Host lowers the framing strobe before any shift edges of a write.
// R08 - Host sends address then data, each most significant bit first.
// R09 - Host raises the strobe after bit sixteen; that rise commits the word.
// R10 - Defined addresses: 0 to 14, 62 readback control, 63 soft reset.
// R11 - Data sampled on rising shift edges while strobe low; else ignored.
module twp_write_port
  import twp_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic shift_clk_in,
  input wire logic frame_n_in,
  input wire logic serial_data_in,
  input wire logic [BUS_BITS-1:0] adc_data_in,
  output logic [BUS_BITS-1:0] output_data_bus_out,
  output logic readback_enable_out,
  output logic word_commit_out,
  output logic word_discard_out,
  output logic [NUM_REGS*DATA_BITS-1:0] cfg_regs_out
);

  function automatic logic [DATA_BITS-1:0] slot_of(
    input logic [NUM_REGS*DATA_BITS-1:0] regs,
    input logic [ADDR_BITS-1:0] idx
  );
    slot_of = regs[int'(idx)*DATA_BITS +: DATA_BITS];
  endfunction

  // ---------------- Link domain (shift clock) ----------------
  logic fresh;
  logic link_tag;
  logic [WORD_BITS-1:0] link_word;
  logic [4:0] link_cnt;
  logic [WORD_BITS-1:0] next_link_word;
  logic [4:0] next_link_cnt;
  logic next_link_tag;

  // First edge of a frame restarts the word; strobe high arms it again.
  // Reset arms it too, as the strobe may already stand high at power-up
  always_ff @(posedge shift_clk_in or posedge frame_n_in or posedge rst_in) begin
    if (frame_n_in || rst_in) begin
      fresh <= 1'b1; // R07
    end else begin
      fresh <= 1'b0;
    end
  end

  assign next_link_word = fresh ? {{(WORD_BITS-1){1'b0}}, serial_data_in}
                                : {link_word[WORD_BITS-2:0], serial_data_in}; // R01 R08
  assign next_link_cnt = fresh ? CNT_FIRST
                       : (link_cnt == CNT_OVER) ? CNT_OVER
                       : link_cnt + 5'h01;
  assign next_link_tag = fresh ? ~link_tag : link_tag;

  // Word, count and tag stay still while the strobe is high, so the
  // system side may read them as quasi-static after the strobe rises
  always_ff @(posedge shift_clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_word <= '0;
      link_cnt <= CNT_ZERO;
      link_tag <= 1'b0;
    end else if (!frame_n_in) begin
      link_word <= next_link_word; // R11
      link_cnt <= next_link_cnt;
      link_tag <= next_link_tag;
    end
  end

  // ---------------- System domain ----------------
  logic [SYNC_STAGES-1:0] frame_sync;
  logic frame_prev;
  logic seen_tag;
  logic cap_valid;
  logic [4:0] cap_cnt;
  logic [WORD_BITS-1:0] cap_word;
  logic [DATA_BITS-1:0] rb_ctrl;
  logic [DATA_BITS-1:0] rb_data;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      frame_sync <= '1;
      frame_prev <= 1'b1;
    end else begin
      frame_sync <= {frame_sync[SYNC_STAGES-2:0], frame_n_in};
      frame_prev <= frame_sync[SYNC_STAGES-1];
    end
  end

  wire frame_rise = frame_sync[SYNC_STAGES-1] && !frame_prev; // R09
  wire frame_had_edges = link_tag != seen_tag;

  // Capture one cycle after the synchronised rise; a frame with no edges
  // leaves the tag unchanged and so counts as zero edges
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cap_valid <= 1'b0;
      cap_cnt <= CNT_ZERO;
      cap_word <= '0;
      seen_tag <= 1'b0;
    end else begin
      cap_valid <= frame_rise;
      if (frame_rise) begin
        cap_cnt <= frame_had_edges ? link_cnt : CNT_ZERO;
        cap_word <= link_word;
        seen_tag <= link_tag;
      end
    end
  end

  wire [ADDR_BITS-1:0] cap_addr = cap_word[ADDR_MSB:ADDR_LSB];
  wire [DATA_BITS-1:0] cap_data = cap_word[DATA_MSB:0];
  wire count_ok = cap_valid && cap_cnt == CNT_FULL; // R03 R04
  wire addr_is_reg = cap_addr <= ADDR_LAST_REG; // R10
  wire addr_is_rb = cap_addr == ADDR_READBACK; // R10
  wire addr_is_swrst = cap_addr == ADDR_SOFT_RESET; // R10
  wire addr_defined = addr_is_reg || addr_is_rb || addr_is_swrst;
  wire mem_we = count_ok && addr_is_reg; // R02
  wire rb_we = count_ok && addr_is_rb;
  wire swrst_hit = count_ok && addr_is_swrst && cap_data[SWRST_BIT];
  wire next_commit = count_ok && addr_defined;
  wire next_discard = cap_valid && !next_commit; // R04 R05
  wire [BUS_BITS-1:0] next_bus = readback_enable_out ?
                                 {rb_data, {RB_LSB{1'b0}}} : adc_data_in; // R06

  // Readback control follows the array's soft reset as well
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || swrst_hit) begin
      rb_ctrl <= DEF_READBACK;
    end else if (rb_we) begin
      rb_ctrl <= cap_data; // R10
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      word_commit_out <= 1'b0;
      word_discard_out <= 1'b0;
      readback_enable_out <= 1'b0;
      output_data_bus_out <= '0;
    end else begin
      word_commit_out <= next_commit;
      word_discard_out <= next_discard;
      readback_enable_out <= rb_ctrl[RB_EN_BIT];
      output_data_bus_out <= next_bus;
    end
  end

  twp_reg_array #(
    .DEPTH(NUM_REGS),
    .WIDTH(DATA_BITS),
    .DEFAULTS(REG_DEFAULTS)
  ) u_regs (
    .clk_in(clk_sys_in),
    .rst_in(rst_in),
    .soft_rst_in(swrst_hit),
    .we_in(mem_we),
    .waddr_in(cap_addr),
    .wdata_in(cap_data),
    .raddr_in(rb_ctrl[RB_SEL_MSB:0]),
    .rdata_out(rb_data),
    .all_out(cfg_regs_out)
  );

  // ---------------- Checks ----------------
  logic [ADDR_BITS-1:0] last_waddr;
  logic [DATA_BITS-1:0] last_wdata;

  always_ff @(posedge clk_sys_in) begin
    last_waddr <= cap_addr;
    last_wdata <= cap_data;
  end

  a_shift_in_bit: assert property ( // R11
    @(posedge shift_clk_in) disable iff (rst_in || frame_n_in)
    !fresh |=> link_word[0] == $past(serial_data_in) &&
               link_word[WORD_BITS-1:1] == $past(link_word[WORD_BITS-2:0]))
    else $error("shift word did not take the serial bit");

  a_edge_count_step: assert property ( // R01
    @(posedge shift_clk_in) disable iff (rst_in || frame_n_in)
    !fresh && link_cnt < CNT_OVER |=> link_cnt == $past(link_cnt) + 5'h01)
    else $error("edge count did not advance");

  a_capture_after_rise: assert property ( // R09
    @(posedge clk_sys_in) disable iff (rst_in)
    frame_rise |=> cap_valid ##1 (word_commit_out != word_discard_out))
    else $error("strobe rise not followed by a verdict");

  a_commit_exact_sixteen: assert property ( // R03
    @(posedge clk_sys_in) disable iff (rst_in)
    word_commit_out |-> $past(cap_valid) && $past(cap_cnt) == CNT_FULL)
    else $error("commit without exactly sixteen edges");

  a_bad_count_discard: assert property ( // R04
    @(posedge clk_sys_in) disable iff (rst_in)
    cap_valid && cap_cnt != CNT_FULL |-> !mem_we && !rb_we && !swrst_hit
      ##1 word_discard_out && $stable(cfg_regs_out))
    else $error("bad edge count changed state");

  a_write_lands: assert property ( // R02
    @(posedge clk_sys_in) disable iff (rst_in)
    mem_we |=> slot_of(cfg_regs_out, last_waddr) == last_wdata && word_commit_out)
    else $error("register write did not land");

  a_undef_addr_discard: assert property ( // R05
    @(posedge clk_sys_in) disable iff (rst_in)
    count_ok && !addr_defined |=> $stable(cfg_regs_out) && $stable(rb_ctrl)
      && word_discard_out)
    else $error("undefined address changed a register");

  a_soft_reset_defaults: assert property ( // R10
    @(posedge clk_sys_in) disable iff (rst_in)
    swrst_hit |=> cfg_regs_out == REG_DEFAULTS ##1 !readback_enable_out)
    else $error("soft reset did not restore defaults");

  a_readback_ctrl: assert property ( // R10
    @(posedge clk_sys_in) disable iff (rst_in)
    rb_we |=> ##1 readback_enable_out == $past(cap_data[RB_EN_BIT], 2))
    else $error("readback enable not taken from control write");

  a_readback_bus: assert property ( // R06
    @(posedge clk_sys_in) disable iff (rst_in)
    readback_enable_out |=> output_data_bus_out == {$past(rb_data), 2'b00})
    else $error("readback bus does not show the selected register");

  // Shift-domain checks only run inside a frame; a raised strobe aborts them
  a_first_edge_restart: assert property ( // R01
    @(posedge shift_clk_in) disable iff (rst_in || frame_n_in)
    fresh |=> link_cnt == CNT_FIRST &&
      link_word == {{(WORD_BITS-1){1'b0}}, $past(serial_data_in)})
    else $error("first shift edge did not restart the word");

  a_count_holds_over: assert property ( // R04
    @(posedge shift_clk_in) disable iff (rst_in || frame_n_in)
    !fresh && link_cnt == CNT_OVER |=>
      link_cnt == CNT_OVER)
    else $error("over-length edge count wrapped");

  a_zero_edge_discard: assert property ( // R04
    @(posedge clk_sys_in) disable iff (rst_in)
    cap_valid && cap_cnt == CNT_ZERO |=>
      word_discard_out && !word_commit_out)
    else $error("frame without edges was not discarded");

  a_count_ok_commit: assert property ( // R02
    @(posedge clk_sys_in) disable iff (rst_in)
    count_ok && addr_defined |=>
      word_commit_out && !word_discard_out)
    else $error("valid word was not committed");

  a_verdict_needs_capture: assert property ( // R03
    @(posedge clk_sys_in) disable iff (rst_in)
    !cap_valid && !rst_in |=>
      !word_commit_out && !word_discard_out)
    else $error("verdict pulse without a captured word");

  a_capture_hold: assert property ( // R09
    @(posedge clk_sys_in) disable iff (rst_in)
    !frame_rise && !rst_in |=>
      $stable(cap_word) && $stable(cap_cnt))
    else $error("captured word moved without a strobe rise");

  // Registers move only on a commit, a soft reset or a system reset
  a_regs_hold_idle: assert property ( // R04
    @(posedge clk_sys_in) disable iff (rst_in)
    !mem_we && !swrst_hit && !rst_in |=>
      $stable(cfg_regs_out))
    else $error("register changed without a commit");

  a_rb_ctrl_hold: assert property ( // R10
    @(posedge clk_sys_in) disable iff (rst_in)
    !rb_we && !swrst_hit && !rst_in |=>
      $stable(rb_ctrl))
    else $error("readback control changed without a write");

  a_swrst_needs_bit: assert property ( // R10
    @(posedge clk_sys_in) disable iff (rst_in)
    count_ok && addr_is_swrst && !cap_data[SWRST_BIT] |=>
      $stable(cfg_regs_out) && word_commit_out)
    else $error("reset word without its bit changed state");

  a_rb_out_of_range: assert property ( // R06
    @(posedge clk_sys_in) disable iff (rst_in)
    rb_ctrl[RB_SEL_MSB:0] > ADDR_LAST_REG && !rst_in |=>
      rb_data == '0)
    else $error("unmapped readback selection did not read zero");

  a_bus_shows_input: assert property ( // R06
    @(posedge clk_sys_in) disable iff (rst_in)
    !readback_enable_out && !rst_in |=>
      output_data_bus_out == $past(adc_data_in))
    else $error("bus does not follow the sample input");

  c_word_commit: cover property (@(posedge clk_sys_in) disable iff (rst_in) mem_we);
  c_word_discard: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    cap_valid && cap_cnt != CNT_FULL);
  c_readback_on: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(readback_enable_out));
  c_soft_reset: cover property (@(posedge clk_sys_in) disable iff (rst_in) swrst_hit);
  c_zero_edge_frame: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    cap_valid && cap_cnt == CNT_ZERO);

endmodule // twp_write_port

// ===== hdl/twp_pkg.sv
// Constants shared by the three-wire write port and its register array
package twp_pkg;

  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam int DATA_BITS = 10;
  localparam int NUM_REGS = 15;
  localparam int BUS_BITS = 12;
  localparam int RB_LSB = 2;
  localparam int SYNC_STAGES = 2;

  // Field positions inside the shifted word
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 10;
  localparam int DATA_MSB = 9;
  localparam int RB_EN_BIT = 9;
  localparam int RB_SEL_MSB = 5;
  localparam int SWRST_BIT = 0;

  // Edge counter: one more than a full word marks an over-length frame
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_FIRST = 5'h01;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_OVER = 5'h11;

  // Address decode
  localparam logic [5:0] ADDR_LAST_REG = 6'h0E;
  localparam logic [5:0] ADDR_READBACK = 6'h3E;
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h3F;

  // Reset values, index 0 in the low slice
  localparam logic [9:0] DEF_GAIN = 10'h000;
  localparam logic [9:0] DEF_OFFSET = 10'h080;
  localparam logic [9:0] DEF_CALIB = 10'h29C;
  localparam logic [9:0] DEF_WAIT_A = 10'h000;
  localparam logic [9:0] DEF_WAIT_B = 10'h001;
  localparam logic [9:0] DEF_OB_LINES = 10'h000;
  localparam logic [9:0] DEF_CDAC = 10'h000;
  localparam logic [9:0] DEF_FDAC = 10'h000;
  localparam logic [9:0] DEF_CONTROL = 10'h020;
  localparam logic [9:0] DEF_POLARITY = 10'h000;
  localparam logic [9:0] DEF_CLOCK = 10'h000;
  localparam logic [9:0] DEF_DELAY_A = 10'h000;
  localparam logic [9:0] DEF_DELAY_B = 10'h000;
  localparam logic [9:0] DEF_DAC0 = 10'h000;
  localparam logic [9:0] DEF_DAC1 = 10'h000;
  localparam logic [9:0] DEF_READBACK = 10'h000;

  localparam logic [NUM_REGS*DATA_BITS-1:0] REG_DEFAULTS = {
    DEF_DAC1, DEF_DAC0, DEF_DELAY_B, DEF_DELAY_A, DEF_CLOCK,
    DEF_POLARITY, DEF_CONTROL, DEF_FDAC, DEF_CDAC, DEF_OB_LINES,
    DEF_WAIT_B, DEF_WAIT_A, DEF_CALIB, DEF_OFFSET, DEF_GAIN
  };

endpackage

// ===== hdl/twp_reg_array.sv
// Register array of the write port with registered read port
module twp_reg_array
  import twp_pkg::*;
#(
  parameter int DEPTH = NUM_REGS,
  parameter int WIDTH = DATA_BITS,
  parameter logic [DEPTH*WIDTH-1:0] DEFAULTS = REG_DEFAULTS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire logic we_in,
  input wire logic [ADDR_BITS-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [ADDR_BITS-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out,
  output logic [DEPTH*WIDTH-1:0] all_out
);

  logic [WIDTH-1:0] mem [DEPTH];
  wire raddr_ok = int'(raddr_in) < DEPTH;

  always_ff @(posedge clk_in) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (rst_in || soft_rst_in) begin
        mem[i] <= DEFAULTS[i*WIDTH +: WIDTH];
      end else if (we_in && int'(waddr_in) == i) begin
        mem[i] <= wdata_in;
      end
    end
  end

  // Out-of-range selections read as zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= raddr_ok ? mem[raddr_in[3:0]] : '0;
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_out[i*WIDTH +: WIDTH] = mem[i];
    end
  end

endmodule // twp_reg_array

// ===== testbench/twp_host_model.sv
// Behavioural host that frames and shifts one word per start request
module twp_host_model (
  input wire logic clk_sys_in,
  input wire logic start_in,
  input wire logic [15:0] word_in,
  input wire logic [4:0] edges_in,
  output logic shift_clk_out,
  output logic frame_n_out,
  output logic serial_data_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int i;
  initial begin
    shift_clk_out = 1'b0;
    frame_n_out = 1'b1;
    serial_data_out = 1'b0;
    busy_out = 1'b0;
  end
  // Shift clock runs only inside a frame, 15 ns period, data 10 ns ahead
  always begin
    @(posedge clk_sys_in iff start_in === 1'b1);
    busy_out = 1'b1;
    #3 frame_n_out = 1'b0;
    for (i = 0; i < edges_in; i++) begin
      serial_data_out = (i < 16) ? word_in[15 - i] : ~serial_data_out;
      #10 shift_clk_out = 1'b1;
      #5 shift_clk_out = 1'b0;
    end
    #10 frame_n_out = 1'b1;
    // Released line must not keep the last bit
    serial_data_out = ~serial_data_out;
    #100 busy_out = 1'b0;
  end
endmodule // twp_host_model

// ===== testbench/three_wire_register_write_port_bench.sv
// Self-checking bench for the three-wire write port
module three_wire_register_write_port_bench
  import twp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b0;
  logic start = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [4:0] edges = 5'h10;
  logic [BUS_BITS-1:0] adc = 12'h0a5;
  logic [BUS_BITS-1:0] adc_seen = 12'h000;
  logic off_q = 1'b0;
  wire logic shift_clk, frame_n, sdata, busy, rb_en, commit, discard;
  wire logic [BUS_BITS-1:0] bus;
  wire logic [NUM_REGS*DATA_BITS-1:0] regs;
  logic [NUM_REGS*DATA_BITS-1:0] exp_regs;
  logic exp_rb;
  logic [5:0] exp_sel;
  logic [31:0] lfsr_q = 32'h0000_141f;
  logic [20:0] corner [13] = '{
    {5'h0f, 6'h00, 10'h3ff}, {5'h11, 6'h00, 10'h3ff}, {5'h00, 6'h00, 10'h3ff},
    {5'h10, 6'h0f, 10'h155}, {5'h10, 6'h3d, 10'h155}, {5'h10, 6'h0e, 10'h2aa},
    {5'h10, 6'h3e, 10'h201}, {5'h10, 6'h3e, 10'h214}, {5'h10, 6'h3e, 10'h20e},
    {5'h10, 6'h3f, 10'h000}, {5'h10, 6'h3f, 10'h001}, {5'h10, 6'h3e, 10'h000},
    {5'h14, 6'h01, 10'h155}};
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int k;
  int idx;

  twp_write_port u_twp_write_port (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .shift_clk_in(shift_clk), .frame_n_in(frame_n), .serial_data_in(sdata),
    .adc_data_in(adc), .output_data_bus_out(bus), .readback_enable_out(rb_en),
    .word_commit_out(commit), .word_discard_out(discard), .cfg_regs_out(regs));
  twp_host_model u_twp_host_model (.clk_sys_in(clk_sys_in), .start_in(start),
    .word_in(word), .edges_in(edges), .shift_clk_out(shift_clk), .frame_n_out(frame_n),
    .serial_data_out(sdata), .busy_out(busy));

  initial forever #5 clk_sys_in = ~clk_sys_in;

  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] rb_val(input logic [5:0] s);
    return (s <= ADDR_LAST_REG) ? {exp_regs[s*10 +: 10], 2'b00} : 12'h000;
  endfunction

  task automatic check(input logic [149:0] got, input logic [149:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apply(input logic [15:0] w);
    if (w[15:10] == ADDR_SOFT_RESET) begin
      if (w[SWRST_BIT]) begin
        exp_regs = REG_DEFAULTS;
        exp_rb = 1'b0;
        exp_sel = 6'h00;
      end
    end else if (w[15:10] == ADDR_READBACK) begin
      exp_rb = w[RB_EN_BIT];
      exp_sel = w[5:0];
    end else begin
      exp_regs[w[15:10]*10 +: 10] = w[9:0];
    end
  endtask

  task automatic send(input logic [15:0] w, input logic [4:0] n);
    logic good;
    int t;
    good = (n == 5'h10) && (w[15:10] <= ADDR_LAST_REG || w[15:10] >= ADDR_READBACK);
    @(posedge clk_sys_in);
    word <= w;
    edges <= n;
    start <= 1'b1;
    @(posedge clk_sys_in);
    start <= 1'b0;
    for (t = 0; t < 100 && commit !== 1'b1 && discard !== 1'b1; t++) @(negedge clk_sys_in);
    check({commit, discard}, {good, !good});
    if (good) apply(w);
    @(negedge clk_sys_in);
    check(regs, exp_regs);
    check(rb_en, exp_rb);
    if (exp_rb) begin
      @(negedge clk_sys_in);
      check(bus, rb_val(exp_sel));
    end
    wait (busy === 1'b0);
  endtask

  // Sample bus only when readback has been off for two cycles
  always @(negedge clk_sys_in) begin
    if (off_q && !rst_in && rb_en === 1'b0) check(bus, adc_seen);
    off_q <= !rst_in && rb_en === 1'b0;
    adc_seen <= adc;
  end

  always @(posedge clk_sys_in) begin
    adc <= adc + 12'h3b1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    exp_regs = REG_DEFAULTS;
    exp_rb = 1'b0;
    exp_sel = 6'h00;
    // A rising reset edge is needed: the link side has no clock yet
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    check(regs, exp_regs);
    for (k = 0; k < 53; k++) begin
      lfsr_q = next_lfsr(lfsr_q);
      idx = (k < 7) ? k : k - 40;
      if (k >= 7 && k < 47) send({6'(lfsr_q[31:16] % 15), lfsr_q[9:0]}, 5'h10);
      else send(corner[idx][15:0], corner[idx][20:16]);
    end
    give_verdict();
  end
endmodule // three_wire_register_write_port_bench
